// ### include/pmsd_cfg.svh
// Functional notes
// - PHY-select strap 0000 routes the media interface to the internal PHY.
// - PHY-select strap 0001 selects external PHY with crystal clocking.
// - PHY-select strap 0010 selects external PHY with oscillator clocking.
// - External PHY mode takes its clock from crystal or oscillator pin.
// - Link-setup 000 autonegotiates advertising every speed and duplex.
// - Link-setup 001 autonegotiates advertising only 100 Mb/s full and half.
// - Link-setup 010 autonegotiates advertising only 10 Mb/s full and half.
// - Link-setup 100 and 101 force 100 Mb/s full and half duplex.
// - Link-setup 110 and 111 force 10 Mb/s full and half duplex.
// - Link-setup captured at reset, held despite later pin changes.
// - Differential media pins are used only in internal PHY mode.
// - PHY-select switches the interface manager to internal or external PHY.
`ifndef PMSD_CFG_SVH
`define PMSD_CFG_SVH

// phy-select strap encodings
`define PMSD_PHY_INTERNAL   4'h0
`define PMSD_PHY_EXT_XTAL   4'h1
`define PMSD_PHY_EXT_OSC    4'h2

// link-setup strap encodings
`define PMSD_LINK_AN_ALL    3'h0
`define PMSD_LINK_AN_100    3'h1
`define PMSD_LINK_AN_10     3'h2
`define PMSD_LINK_RESERVED  3'h3
`define PMSD_LINK_F100_FDX  3'h4
`define PMSD_LINK_F100_HDX  3'h5
`define PMSD_LINK_F10_FDX   3'h6
`define PMSD_LINK_F10_HDX   3'h7

// cycles the synchronised straps must settle after reset release
`define PMSD_SETTLE_CYCLES  4'h4
`define PMSD_SETTLE_ONE     4'h1

// register byte offsets
`define PMSD_OFF_STATUS     4'h0
`define PMSD_OFF_CTRL       4'h4
`define PMSD_OFF_LINK       4'h8

// control register
`define PMSD_CTRL_RESET     1'h1
`define PMSD_CTRL_PHY_EN    0

// axi responses
`define PMSD_RESP_OKAY      2'h0
`define PMSD_RESP_SLVERR    2'h2

`endif

// ### include/pmsd_pkg.sv
package pmsd_pkg;

  // strap capture sequence
  typedef enum logic [1:0] {
    PMSD_ST_RESET,
    PMSD_ST_SETTLE,
    PMSD_ST_LOCKED
  } pmsd_state_t;

  // register selected by an address
  typedef enum logic [1:0] {
    PMSD_SEL_NONE,
    PMSD_SEL_STATUS,
    PMSD_SEL_CTRL,
    PMSD_SEL_LINK
  } pmsd_sel_t;

endpackage

// ### verilog/pmsd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pmsd_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // three-stage chain; first stage feeds only the second
  always_ff @(posedge aclk) begin
    s1_reg <= async_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out <= '0;
    end else if (s2_reg == s3_reg) begin
      sync_out <= s3_reg;
    end
  end

endmodule

`default_nettype wire

// ### verilog/pmsd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmsd_cfg.svh"

module pmsd_top
  import pmsd_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // configuration straps
  input  wire logic [3:0]        phy_select_strap,
  input  wire logic [2:0]        link_setup_strap,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // decoded media-interface controls
  output var  logic              straps_valid,
  output var  logic              mii_internal_sel,
  output var  logic              mii_external_sel,
  output var  logic              ext_clk_xtal_sel,
  output var  logic              ext_clk_osc_sel,
  output var  logic              media_pins_enable,
  output var  logic              internal_phy_enable,
  output var  logic              phy_select_reserved,
  output var  logic              autoneg_enable,
  output var  logic              adv_100_fdx,
  output var  logic              adv_100_hdx,
  output var  logic              adv_10_fdx,
  output var  logic              adv_10_hdx,
  output var  logic              force_speed_100,
  output var  logic              force_full_duplex,
  output var  logic              link_setup_reserved
);

  // map an address onto a register
  function automatic pmsd_sel_t reg_select(input logic [ADDR_W-1:0] addr);
    logic [3:0] off;
    off = addr[3:0];
    case (off)
      `PMSD_OFF_STATUS: reg_select = PMSD_SEL_STATUS;
      `PMSD_OFF_CTRL:   reg_select = PMSD_SEL_CTRL;
      `PMSD_OFF_LINK:   reg_select = PMSD_SEL_LINK;
      default:          reg_select = PMSD_SEL_NONE;
    endcase
  endfunction

  // synchronised strap levels
  logic [3:0]  phy_sync;
  logic [2:0]  link_sync;

  // capture sequence
  pmsd_state_t state_reg;
  logic [3:0]  settle_reg;
  logic        capture;

  // captured straps
  logic [3:0]  phy_cap_reg;
  logic [2:0]  link_cap_reg;

  // software control
  logic        ctrl_phy_en_reg;

  // write channel holding state
  logic              aw_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic              w_held_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              wr_fire;
  pmsd_sel_t         wr_sel;

  // read channel
  pmsd_sel_t         rd_sel;
  logic [31:0]       rd_word;
  logic              ar_take;

  // status words
  logic [31:0]       status_word;
  logic [31:0]       link_word;

  // pin straps pass the three-stage chain
  pmsd_sync #(
    .WIDTH (4)
  ) u_phy_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (phy_select_strap),
    .sync_out (phy_sync)
  );

  pmsd_sync #(
    .WIDTH (3)
  ) u_link_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (link_setup_strap),
    .sync_out (link_sync)
  );

  // capture sequence: wait for the chain to fill, then lock once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= PMSD_ST_RESET;
      settle_reg <= `PMSD_SETTLE_CYCLES;
    end else begin
      case (state_reg)
        PMSD_ST_RESET: begin
          state_reg  <= PMSD_ST_SETTLE;
          settle_reg <= `PMSD_SETTLE_CYCLES;
        end
        PMSD_ST_SETTLE: begin
          if (settle_reg == `PMSD_SETTLE_ONE) begin
            state_reg <= PMSD_ST_LOCKED;
          end else begin
            settle_reg <= settle_reg - `PMSD_SETTLE_ONE;
          end
        end
        PMSD_ST_LOCKED: begin
          state_reg <= PMSD_ST_LOCKED; // held until next reset
        end
        default: begin
          state_reg <= PMSD_ST_RESET;
        end
      endcase
    end
  end

  assign capture = (state_reg == PMSD_ST_SETTLE) &&
                   (settle_reg == `PMSD_SETTLE_ONE);

  // latch straps once after reset; later pin changes ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_cap_reg  <= `PMSD_PHY_INTERNAL;
      link_cap_reg <= `PMSD_LINK_AN_ALL;
      straps_valid <= 1'b0;
    end else if (capture) begin
      phy_cap_reg  <= phy_sync;
      link_cap_reg <= link_sync;
      straps_valid <= 1'b1;
    end
  end

  // phy-select decode, loaded with the capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mii_internal_sel    <= 1'b0;
      mii_external_sel    <= 1'b0;
      ext_clk_xtal_sel    <= 1'b0;
      ext_clk_osc_sel     <= 1'b0;
      media_pins_enable   <= 1'b0;
      phy_select_reserved <= 1'b0;
    end else if (capture) begin
      mii_internal_sel    <= 1'b0;
      mii_external_sel    <= 1'b0;
      ext_clk_xtal_sel    <= 1'b0;
      ext_clk_osc_sel     <= 1'b0;
      media_pins_enable   <= 1'b0;
      phy_select_reserved <= 1'b0;
      case (phy_sync)
        `PMSD_PHY_INTERNAL: begin
          mii_internal_sel  <= 1'b1;
          media_pins_enable <= 1'b1;
        end
        `PMSD_PHY_EXT_XTAL: begin
          mii_external_sel <= 1'b1;
          ext_clk_xtal_sel <= 1'b1; // crystal pin
        end
        `PMSD_PHY_EXT_OSC: begin
          mii_external_sel <= 1'b1;
          ext_clk_osc_sel  <= 1'b1; // oscillator pin
        end
        default: begin
          phy_select_reserved <= 1'b1; // factory codes, nothing routed
        end
      endcase
    end
  end

  // link-setup decode, loaded with the capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      autoneg_enable      <= 1'b0;
      adv_100_fdx         <= 1'b0;
      adv_100_hdx         <= 1'b0;
      adv_10_fdx          <= 1'b0;
      adv_10_hdx          <= 1'b0;
      force_speed_100     <= 1'b0;
      force_full_duplex   <= 1'b0;
      link_setup_reserved <= 1'b0;
    end else if (capture) begin
      autoneg_enable      <= 1'b0;
      adv_100_fdx         <= 1'b0;
      adv_100_hdx         <= 1'b0;
      adv_10_fdx          <= 1'b0;
      adv_10_hdx          <= 1'b0;
      force_speed_100     <= 1'b0;
      force_full_duplex   <= 1'b0;
      link_setup_reserved <= 1'b0;
      case (link_sync)
        `PMSD_LINK_AN_ALL: begin
          autoneg_enable <= 1'b1;
          adv_100_fdx    <= 1'b1;
          adv_100_hdx    <= 1'b1;
          adv_10_fdx     <= 1'b1;
          adv_10_hdx     <= 1'b1;
        end
        `PMSD_LINK_AN_100: begin
          autoneg_enable <= 1'b1;
          adv_100_fdx    <= 1'b1;
          adv_100_hdx    <= 1'b1;
        end
        `PMSD_LINK_AN_10: begin
          autoneg_enable <= 1'b1;
          adv_10_fdx     <= 1'b1;
          adv_10_hdx     <= 1'b1;
        end
        `PMSD_LINK_F100_FDX: begin
          force_speed_100   <= 1'b1;
          force_full_duplex <= 1'b1;
        end
        `PMSD_LINK_F100_HDX: begin
          force_speed_100 <= 1'b1;
        end
        `PMSD_LINK_F10_FDX: begin
          force_full_duplex <= 1'b1;
        end
        `PMSD_LINK_F10_HDX: begin
          force_speed_100 <= 1'b0; // 10 Mb/s half duplex
        end
        default: begin
          link_setup_reserved <= 1'b1; // unsupported code
        end
      endcase
    end
  end

  // internal phy runs only when selected and software allows it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_phy_enable <= 1'b0;
    end else begin
      internal_phy_enable <= straps_valid && mii_internal_sel &&
                             ctrl_phy_en_reg;
    end
  end

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_sel        = reg_select(awaddr_reg);

  // hold the write address until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // hold the write data until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // control register, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_phy_en_reg <= `PMSD_CTRL_RESET;
    end else if (wr_fire && wr_sel == PMSD_SEL_CTRL && wstrb_reg[0]) begin
      ctrl_phy_en_reg <= wdata_reg[`PMSD_CTRL_PHY_EN];
    end
  end

  // write response; read-only and unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PMSD_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == PMSD_SEL_CTRL) ? `PMSD_RESP_OKAY
                                                : `PMSD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // status and link words seen by software
  assign status_word = {21'h000000, link_setup_reserved, phy_select_reserved,
                        straps_valid, 1'b0, link_cap_reg, phy_cap_reg};
  assign link_word   = {23'h000000, ctrl_phy_en_reg, force_full_duplex,
                        force_speed_100, adv_10_hdx, adv_10_fdx,
                        adv_100_hdx, adv_100_fdx, autoneg_enable};

  // read mux
  assign rd_sel = reg_select(s_axi_araddr);

  always_comb begin
    case (rd_sel)
      PMSD_SEL_STATUS: rd_word = status_word;
      PMSD_SEL_CTRL:   rd_word = {31'h00000000, ctrl_phy_en_reg};
      PMSD_SEL_LINK:   rd_word = link_word;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // read channel: one read at a time, answered the next cycle
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PMSD_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_sel == PMSD_SEL_NONE) ? `PMSD_RESP_SLVERR
                                                : `PMSD_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### test/pmsd_properties.sv
`timescale 1ns/1ps
`default_nettype none

module pmsd_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic straps_valid,
  input wire logic mii_internal_sel,
  input wire logic mii_external_sel,
  input wire logic ext_clk_xtal_sel,
  input wire logic ext_clk_osc_sel,
  input wire logic media_pins_enable,
  input wire logic autoneg_enable,
  input wire logic adv_100_fdx,
  input wire logic adv_100_hdx,
  input wire logic adv_10_fdx,
  input wire logic adv_10_hdx,
  input wire logic force_speed_100,
  input wire logic link_setup_reserved
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // two sampled edges with captured straps
  sequence s_locked;
    straps_valid [*2];
  endsequence

  // media routing and clock source follow the phy strap
  a_int_route: assert property (
    mii_internal_sel |-> media_pins_enable && !mii_external_sel)
    else $error("internal route wrong");
  a_xtal_clock: assert property (
    ext_clk_xtal_sel |-> mii_external_sel && !ext_clk_osc_sel)
    else $error("crystal source wrong");
  a_osc_clock: assert property (
    ext_clk_osc_sel |-> mii_external_sel && !ext_clk_xtal_sel)
    else $error("oscillator source wrong");
  a_ext_source: assert property (
    mii_external_sel |-> ext_clk_xtal_sel != ext_clk_osc_sel)
    else $error("external mode without one source");
  // captured controls stay put until the next reset
  a_decode_hold: assert property (
    s_locked |-> $stable({mii_internal_sel, mii_external_sel,
      ext_clk_xtal_sel, autoneg_enable, adv_100_fdx, adv_10_fdx,
      force_speed_100, link_setup_reserved}))
    else $error("decoded controls moved");
  // advertising only in pairs, only under autonegotiation
  a_adv_pairs: assert property (
    autoneg_enable |-> adv_100_fdx == adv_100_hdx
      && adv_10_fdx == adv_10_hdx && (adv_100_fdx || adv_10_fdx)
      && !force_speed_100)
    else $error("advertised set wrong");
  a_forced_quiet: assert property (
    straps_valid && !autoneg_enable |-> !(adv_100_fdx || adv_100_hdx
      || adv_10_fdx || adv_10_hdx))
    else $error("forced mode advertises");
  a_reserved_link: assert property (
    link_setup_reserved |-> !autoneg_enable && !force_speed_100)
    else $error("reserved link setup acts");
  // bus answers
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_stand: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule

`default_nettype wire

// ### test/pmsd_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module pmsd_strap_board (
  input  wire logic       aclk,
  input  wire logic [3:0] phy_req,
  input  wire logic [2:0] link_req,
  output var  logic [3:0] phy_select_strap,
  output var  logic [2:0] link_setup_strap
);
  // board wiring; a factory code appears only when the bench asks for it
  always_ff @(posedge aclk) begin
    phy_select_strap <= phy_req;
    link_setup_strap <= link_req;
  end
endmodule

`default_nettype wire

// ### test/test_pmsd_top.sv
`timescale 1ns/1ps
`default_nettype none

module test_pmsd_top;
  logic        aclk = 0, aresetn = 0;
  logic [3:0]  phy_req = 0, s_axi_awaddr = 0, s_axi_araddr = 0, ph;
  logic [2:0]  link_req = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0]  phy_select_strap;
  logic [2:0]  link_setup_strap;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, straps_valid;
  logic        mii_internal_sel, mii_external_sel, ext_clk_xtal_sel;
  logic        ext_clk_osc_sel, media_pins_enable, internal_phy_enable;
  logic        phy_select_reserved, autoneg_enable, adv_100_fdx;
  logic        adv_100_hdx, adv_10_fdx, adv_10_hdx, force_speed_100;
  logic        force_full_duplex, link_setup_reserved;
  logic [14:0] dec, e;
  int          num_errors = 0, total_checks = 0, cycles = 0;
  logic [7:0]  link_tbl [8] = '{8'hf8, 8'he0, 8'h98, 8'h01,
                                8'h06, 8'h04, 8'h02, 8'h00};

  assign dec = {straps_valid, mii_internal_sel, mii_external_sel,
    ext_clk_xtal_sel, ext_clk_osc_sel, media_pins_enable,
    phy_select_reserved, autoneg_enable, adv_100_fdx, adv_100_hdx,
    adv_10_fdx, adv_10_hdx, force_speed_100, force_full_duplex,
    link_setup_reserved};

  pmsd_strap_board i_pmsd_strap_board (.aclk, .phy_req, .link_req,
    .phy_select_strap, .link_setup_strap);

  pmsd_top i_pmsd_top (.aclk, .aresetn, .phy_select_strap,
    .link_setup_strap, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .straps_valid, .mii_internal_sel, .mii_external_sel, .ext_clk_xtal_sel,
    .ext_clk_osc_sel, .media_pins_enable, .internal_phy_enable,
    .phy_select_reserved, .autoneg_enable, .adv_100_fdx, .adv_100_hdx,
    .adv_10_fdx, .adv_10_hdx, .force_speed_100, .force_full_duplex,
    .link_setup_reserved);

  // clock and hang guard
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  // expected decode of a strap pair
  function automatic logic [14:0] exp_dec(input logic [3:0] p,
                                          input logic [2:0] l);
    logic [5:0] r;
    r = (p == 4'h0) ? 6'h22 : (p == 4'h1) ? 6'h18 :
        (p == 4'h2) ? 6'h14 : 6'h01;
    return {1'b1, r, link_tbl[l]};
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  // reset with straps held, then wait for capture
  task strap_reset(input logic [3:0] p, input logic [2:0] l);
    int n;
    aresetn <= 1'b0;
    phy_req <= p;
    link_req <= l;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    while (straps_valid !== 1'b1 && n < 20) begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
  endtask

  task axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r), "bresp");
    // one idle edge so the next transfer starts from released signals
    @(posedge aclk);
  endtask

  task axi_rd(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, v, "rdata");
    chk(32'(s_axi_rresp), 32'(r), "rresp");
    // one idle edge so the next transfer starts from released signals
    @(posedge aclk);
  endtask

  task complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // every link code with phy codes 0-2 and a random factory code, then later pin noise, then the register path
  initial begin
    void'($urandom(37));
    for (int p = 0; p < 4; p++) begin
      for (int l = 0; l < 8; l++) begin
        ph = (p == 3) ? 4'($urandom_range(15, 3)) : 4'(p);
        strap_reset(ph, 3'(l));
        e = exp_dec(ph, 3'(l));
        chk(32'(dec[14:8]), 32'(e[14:8]), "phy");
        chk(32'(dec[7:0]), 32'(e[7:0]), "link");
        phy_req <= 4'($urandom);
        link_req <= 3'($urandom);
        repeat (8) @(posedge aclk);
        chk(32'(dec), 32'(exp_dec(ph, 3'(l))), "held");
      end
      $display("decode group %0d done", p);
    end
    strap_reset(4'h0, 3'h5);
    chk(32'(internal_phy_enable), 32'h1, "phy enable");
    axi_rd(4'h0, 32'h150, 2'h0);
    axi_rd(4'h8, 32'ha0, 2'h0);
    d = $urandom;
    d[0] = 1'b0; // always exercise the software disable path
    axi_wr(4'h4, d, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(internal_phy_enable), 32'(d[0]), "ctrl enable");
    axi_rd(4'h4, 32'(d[0]), 2'h0);
    axi_wr(4'h0, 32'hffff, 2'h2);
    axi_rd(4'h0, 32'h150, 2'h0);
    axi_wr(4'hc, 32'h1, 2'h2);
    axi_rd(4'hc, 32'h0, 2'h2);
    axi_wr(4'h4, 32'h1, 2'h0);
    axi_rd(4'h8, 32'ha0, 2'h0);
    $display("register path done");
    complete_run();
  end
endmodule

bind pmsd_top pmsd_properties i_pmsd_properties (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready, .straps_valid, .mii_internal_sel, .mii_external_sel,
  .ext_clk_xtal_sel, .ext_clk_osc_sel, .media_pins_enable, .autoneg_enable,
  .adv_100_fdx, .adv_100_hdx, .adv_10_fdx, .adv_10_hdx, .force_speed_100,
  .link_setup_reserved);

`default_nettype wire
